// ===== rtl/status_pkg.sv
package status_pkg;
   // ==========================================================
   // Widths
   // ==========================================================
   localparam int GRP_W = 16;           // Width of one status group
   localparam int STB_W = 8;            // Status byte width
   localparam int ESR_W = 8;            // Standard event status width
   // ==========================================================
   // Status byte bit positions
   // ==========================================================
   localparam int STB_ERRQ_BIT = 2;     // Error queue not empty
   localparam int STB_QUES_BIT = 3;     // Questionable summary
   localparam int STB_ESB_BIT = 5;      // Standard event summary
   localparam int STB_RQS_BIT = 6;      // Request service
   localparam int STB_OPER_BIT = 7;     // Operation summary
   // ==========================================================
   // Standard event bits
   // ==========================================================
   localparam int ESR_OPC_BIT = 0;      // Operation complete
   localparam int ESR_PON_BIT = 7;      // Power on / mode change
   // Questionable input slot fed by the extra group summary
   localparam int QUES_SUB_BIT = 15;
   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [GRP_W-1:0] PTR_RST = 16'hFFFF;  // Rising edges detected
   localparam logic [GRP_W-1:0] NTR_RST = 16'h0000;  // Falling ignored
   localparam logic [GRP_W-1:0] ENA_RST = 16'h0000;
   localparam logic [STB_W-1:0] SRE_RST = 8'h00;
   localparam logic [ESR_W-1:0] ESE_RST = 8'h00;
   // ==========================================================
   // Group select codes for programming filters and enables
   // ==========================================================
   typedef enum logic [1:0] {
      GRP_QUES,
      GRP_OPER,
      GRP_SUB,
      GRP_NONE
   } grp_sel_t;
   typedef enum logic [1:0] {
      FLD_PTR,
      FLD_NTR,
      FLD_ENA,
      FLD_EVT
   } grp_fld_t;
endpackage

// ===== rtl/status_grp_if.sv
// Programming and readback link between the top and one group
interface status_grp_if #(parameter int W = 16);
   logic [W-1:0] wdata;     // Value to store
   logic wr_ptr;            // Write positive filter
   logic wr_ntr;            // Write negative filter
   logic wr_ena;            // Write event enable
   logic rd_clr;            // Event read, clears event register
   logic [W-1:0] ptr;       // Current positive filter
   logic [W-1:0] ntr;       // Current negative filter
   logic [W-1:0] ena;       // Current enable
   logic [W-1:0] evt;       // Current event register
   logic summary;           // Group summary
   modport ctl (output wdata, wr_ptr, wr_ntr, wr_ena, rd_clr,
      input ptr, ntr, ena, evt, summary);
   modport grp (input wdata, wr_ptr, wr_ntr, wr_ena, rd_clr,
      output ptr, ntr, ena, evt, summary);
endinterface

// ===== rtl/status_group.sv
// One status group: condition, filters, event latch, enable, summary
module status_group #(
   parameter int W = 16,
   parameter logic [W-1:0] PTR_INIT = '1,
   parameter logic [W-1:0] NTR_INIT = '0,
   parameter logic [W-1:0] ENA_INIT = '0
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic clear_i,          // Clear-status or mode change
   input wire logic defaults_i,       // Mode change: masks to defaults
   input wire logic [W-1:0] cond_i,   // Live condition bits
   status_grp_if.grp bus
);
   logic [W-1:0] cond_reg;  // Condition one clock ago, for edges
   logic [W-1:0] ptr_reg;
   logic [W-1:0] ntr_reg;
   logic [W-1:0] ena_reg;
   logic [W-1:0] evt_reg;
   logic [W-1:0] hit;

   // ==========================================================
   // Edge detection
   // ==========================================================
   // live condition
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cond_reg <= '0;
      end else begin
         cond_reg <= cond_i;
      end
   end

   assign hit = (cond_i & ~cond_reg & ptr_reg) | (~cond_i & cond_reg & ntr_reg);

   // ==========================================================
   // Filters and enable
   // ==========================================================
   // rising by default
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ptr_reg <= PTR_INIT;
         ntr_reg <= NTR_INIT;
         ena_reg <= ENA_INIT;
      end else if (defaults_i) begin
         ptr_reg <= PTR_INIT;
         ntr_reg <= NTR_INIT;
         ena_reg <= ENA_INIT;
      end else begin
         if (bus.wr_ptr) begin
            ptr_reg <= bus.wdata;
         end
         if (bus.wr_ntr) begin
            ntr_reg <= bus.wdata;
         end
         if (bus.wr_ena) begin
            ena_reg <= bus.wdata;
         end
      end
   end

   // ==========================================================
   // Event latch
   // ==========================================================
   // sticky events
   // New edges win over a clear in the same cycle, so none is lost
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         evt_reg <= '0;
      end else if (clear_i || bus.rd_clr) begin
         evt_reg <= hit;
      end else begin
         evt_reg <= evt_reg | hit;
      end
   end

   assign bus.ptr = ptr_reg;
   assign bus.ntr = ntr_reg;
   assign bus.ena = ena_reg;
   assign bus.evt = evt_reg;
   assign bus.summary = |(evt_reg & ena_reg);
endmodule

// ===== rtl/status_reporting_hierarchy.sv
// How it works
// - condition registers follow live state
// - enabled falling edge sets event
// - enabled rising edge sets event
// - event bits stay set until cleared
// - summary is OR of event AND enable
// - summaries feed status byte or questionable
// - request is OR of byte AND enable
// - clear-status empties queue and events
// - event enable write and readback
// - event status read clears it
// - operation complete sets bit zero
// - service enable write and readback
// - status byte read clears nothing
// - mode change restores all defaults
// - mode change sets power-up bit
// - device raises request unprompted
// - request service sits at bit six
// - new request only when none pending
// - serial poll clears only request bit
// - filters reset to rising edges
module status_reporting_hierarchy
   import status_pkg::*;
#(
   parameter int W = status_pkg::GRP_W
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Live condition inputs
   input wire logic [W-1:0] ques_cond_i,
   input wire logic [W-1:0] oper_cond_i,
   input wire logic [W-1:0] sub_cond_i,
   input wire logic errq_not_empty_i,         // Error queue holds entries
   input wire logic [ESR_W-1:0] esr_set_i,     // Standard event pulses
   input wire logic ops_idle_i,                // No operation pending
   input wire logic mode_change_i,             // Mode change pulse
   // Group programming
   input wire status_pkg::grp_sel_t grp_sel_i,
   input wire status_pkg::grp_fld_t grp_fld_i,
   input wire logic grp_wr_i,                  // Write selected field
   input wire logic grp_rd_i,                  // Read selected field
   input wire logic [W-1:0] grp_wdata_i,
   output logic [W-1:0] grp_rdata_o,
   // Common commands
   input wire logic cls_i,                     // Clear status
   input wire logic ese_wr_i,
   input wire logic [ESR_W-1:0] ese_wdata_i,
   output logic [ESR_W-1:0] ese_o,
   input wire logic esr_rd_i,                  // Read and clear
   output logic [ESR_W-1:0] esr_rdata_o,
   input wire logic opc_i,                     // Operation complete cmd
   input wire logic sre_wr_i,
   input wire logic [STB_W-1:0] sre_wdata_i,
   output logic [STB_W-1:0] sre_o,
   input wire logic stb_rd_i,                  // Status byte query
   input wire logic spoll_i,                   // Serial poll read
   output logic [STB_W-1:0] stb_o,             // Live status byte
   output logic errq_clear_o,                  // Empty the error queue
   output logic srq_o                          // Service request line
);
   import status_pkg::*;

   // ==========================================================
   // Group links and instances
   // ==========================================================
   status_grp_if #(.W(W)) ques_if ();
   status_grp_if #(.W(W)) oper_if ();
   status_grp_if #(.W(W)) sub_if ();

   logic clear_all;                  // Clear-status or mode change
   logic [W-1:0] ques_in;            // Questionable plus sub summary
   logic [ESR_W-1:0] ese_reg;
   logic [ESR_W-1:0] esr_reg;
   logic [STB_W-1:0] sre_reg;
   logic [STB_W-1:0] stb_reg;
   logic rqs_reg;                    // Request pending
   logic srq_reg;
   logic opc_pend_reg;               // Waiting for operations to end
   logic [W-1:0] grp_rdata_reg;
   logic [ESR_W-1:0] esr_rdata_reg;
   logic errq_clear_reg;
   logic [STB_W-1:0] summ;           // Summary bits without request
   logic mss;                        // Enabled summary
   logic mss_d_reg;                  // Last enabled summary, for edges
   logic [ESR_W-1:0] esr_sets;       // Standard events arriving this cycle

   assign clear_all = cls_i | mode_change_i;

   always_comb begin
      ques_in = ques_cond_i;
      ques_in[QUES_SUB_BIT] = sub_if.summary;
   end

   status_group #(.W(W), .PTR_INIT(W'(PTR_RST)), .NTR_INIT(W'(NTR_RST)),
      .ENA_INIT(W'(ENA_RST))) u_ques (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .clear_i(clear_all),
      .defaults_i(mode_change_i),
      .cond_i(ques_in),
      .bus(ques_if.grp)
   );
   status_group #(.W(W), .PTR_INIT(W'(PTR_RST)), .NTR_INIT(W'(NTR_RST)),
      .ENA_INIT(W'(ENA_RST))) u_oper (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .clear_i(clear_all),
      .defaults_i(mode_change_i),
      .cond_i(oper_cond_i),
      .bus(oper_if.grp)
   );
   status_group #(.W(W), .PTR_INIT(W'(PTR_RST)), .NTR_INIT(W'(NTR_RST)),
      .ENA_INIT(W'(ENA_RST))) u_sub (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .clear_i(clear_all),
      .defaults_i(mode_change_i),
      .cond_i(sub_cond_i),
      .bus(sub_if.grp)
   );

   // ==========================================================
   // Group programming decode
   // ==========================================================
   // Writes go to one field of one group; event reads clear
   always_comb begin
      ques_if.wdata = grp_wdata_i;
      oper_if.wdata = grp_wdata_i;
      sub_if.wdata = grp_wdata_i;
      ques_if.wr_ptr = grp_wr_i && grp_sel_i == GRP_QUES && grp_fld_i == FLD_PTR;
      ques_if.wr_ntr = grp_wr_i && grp_sel_i == GRP_QUES && grp_fld_i == FLD_NTR;
      ques_if.wr_ena = grp_wr_i && grp_sel_i == GRP_QUES && grp_fld_i == FLD_ENA;
      ques_if.rd_clr = grp_rd_i && grp_sel_i == GRP_QUES && grp_fld_i == FLD_EVT;
      oper_if.wr_ptr = grp_wr_i && grp_sel_i == GRP_OPER && grp_fld_i == FLD_PTR;
      oper_if.wr_ntr = grp_wr_i && grp_sel_i == GRP_OPER && grp_fld_i == FLD_NTR;
      oper_if.wr_ena = grp_wr_i && grp_sel_i == GRP_OPER && grp_fld_i == FLD_ENA;
      oper_if.rd_clr = grp_rd_i && grp_sel_i == GRP_OPER && grp_fld_i == FLD_EVT;
      sub_if.wr_ptr = grp_wr_i && grp_sel_i == GRP_SUB && grp_fld_i == FLD_PTR;
      sub_if.wr_ntr = grp_wr_i && grp_sel_i == GRP_SUB && grp_fld_i == FLD_NTR;
      sub_if.wr_ena = grp_wr_i && grp_sel_i == GRP_SUB && grp_fld_i == FLD_ENA;
      sub_if.rd_clr = grp_rd_i && grp_sel_i == GRP_SUB && grp_fld_i == FLD_EVT;
   end

   // Readback register; unselected group reads zero
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         grp_rdata_reg <= '0;
      end else if (grp_rd_i) begin
         case (grp_sel_i)
            GRP_QUES: begin
               case (grp_fld_i)
                  FLD_PTR: grp_rdata_reg <= ques_if.ptr;
                  FLD_NTR: grp_rdata_reg <= ques_if.ntr;
                  FLD_ENA: grp_rdata_reg <= ques_if.ena;
                  default: grp_rdata_reg <= ques_if.evt;
               endcase
            end
            GRP_OPER: begin
               case (grp_fld_i)
                  FLD_PTR: grp_rdata_reg <= oper_if.ptr;
                  FLD_NTR: grp_rdata_reg <= oper_if.ntr;
                  FLD_ENA: grp_rdata_reg <= oper_if.ena;
                  default: grp_rdata_reg <= oper_if.evt;
               endcase
            end
            GRP_SUB: begin
               case (grp_fld_i)
                  FLD_PTR: grp_rdata_reg <= sub_if.ptr;
                  FLD_NTR: grp_rdata_reg <= sub_if.ntr;
                  FLD_ENA: grp_rdata_reg <= sub_if.ena;
                  default: grp_rdata_reg <= sub_if.evt;
               endcase
            end
            default: grp_rdata_reg <= '0;
         endcase
      end
   end

   // ==========================================================
   // Standard event status group
   // ==========================================================
   // event enable mask
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ese_reg <= ESE_RST;
      end else if (mode_change_i) begin
         ese_reg <= ESE_RST;
      end else if (ese_wr_i) begin
         ese_reg <= ese_wdata_i;
      end
   end

   // wait for operations to finish before flagging completion
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         opc_pend_reg <= 1'b0;
      end else if (clear_all) begin
         opc_pend_reg <= 1'b0;
      end else if (opc_i && !ops_idle_i) begin
         opc_pend_reg <= 1'b1;
      end else if (ops_idle_i) begin
         opc_pend_reg <= 1'b0;
      end
   end

   // operation complete joins the incoming event pulses
   // Kept out of the register process so its reset branch stays plain
   always_comb begin
      esr_sets = esr_set_i;
      esr_sets[ESR_OPC_BIT] = esr_set_i[ESR_OPC_BIT] | (ops_idle_i & (opc_i | opc_pend_reg));
   end

   // Event register; incoming sets win over read or clear
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         esr_reg <= '0;
      end else if (mode_change_i) begin
         esr_reg <= ESR_W'(1) << ESR_PON_BIT;
      end else if (cls_i || esr_rd_i) begin
         esr_reg <= esr_sets;
      end else begin
         esr_reg <= esr_reg | esr_sets;
      end
   end

   // read value captured before the clear
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         esr_rdata_reg <= '0;
      end else if (esr_rd_i) begin
         esr_rdata_reg <= esr_reg;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         errq_clear_reg <= 1'b0;
      end else begin
         errq_clear_reg <= clear_all;
      end
   end

   // ==========================================================
   // Status byte and service request
   // ==========================================================
   // summaries into status byte
   always_comb begin
      summ = '0;
      summ[STB_ERRQ_BIT] = errq_not_empty_i;
      summ[STB_QUES_BIT] = ques_if.summary;
      summ[STB_ESB_BIT] = |(esr_reg & ese_reg);
      summ[STB_OPER_BIT] = oper_if.summary;
   end

   // enabled summary, request bit excluded from the mask
   assign mss = |(summ & sre_reg & ~(STB_W'(1) << STB_RQS_BIT));

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sre_reg <= SRE_RST;
      end else if (mode_change_i) begin
         sre_reg <= SRE_RST;
      end else if (sre_wr_i) begin
         sre_reg <= sre_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mss_d_reg <= 1'b0;
      end else begin
         mss_d_reg <= mss;
      end
   end

   // start only on a rise with nothing pending
   // serial poll ends the pending request
   // plain status byte query leaves it alone
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rqs_reg <= 1'b0;
      end else if (clear_all || spoll_i) begin
         rqs_reg <= 1'b0;
      end else if (mss && !mss_d_reg) begin
         rqs_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stb_reg <= '0;
         srq_reg <= 1'b0;
      end else begin
         stb_reg <= summ | ({{(STB_W-1){1'b0}}, rqs_reg} << STB_RQS_BIT);
         srq_reg <= rqs_reg;
      end
   end

   assign grp_rdata_o = grp_rdata_reg;
   assign ese_o = ese_reg;
   assign esr_rdata_o = esr_rdata_reg;
   assign sre_o = sre_reg;
   assign stb_o = stb_reg;
   assign errq_clear_o = errq_clear_reg;
   assign srq_o = srq_reg;
endmodule

// ===== sim/status_checker_assertions.sv
// ==========================================================
// Port checker for the status hierarchy
module status_checker (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic errq_not_empty_i,
   input wire logic mode_change_i,
   input wire logic cls_i,
   input wire logic ese_wr_i,
   input wire logic [status_pkg::ESR_W-1:0] ese_wdata_i,
   input wire logic sre_wr_i,
   input wire logic [status_pkg::STB_W-1:0] sre_wdata_i,
   input wire logic spoll_i,
   input wire logic [status_pkg::ESR_W-1:0] ese_o,
   input wire logic [status_pkg::STB_W-1:0] sre_o,
   input wire logic [status_pkg::STB_W-1:0] stb_o,
   input wire logic errq_clear_o,
   input wire logic srq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import status_pkg::*;
   // One clock domain, so one default clock and disable
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);
   // Poll request and the request bit falling after it
   sequence s_poll;
      spoll_i;
   endsequence
   sequence s_rqs_gone;
      ##[1:2] !stb_o[STB_RQS_BIT];
   endsequence
   // Mode change without a competing mask write
   sequence s_clean_mode;
      mode_change_i && !ese_wr_i && !sre_wr_i;
   endsequence
   AST_SRQ_LINE: assert property (srq_o == stb_o[STB_RQS_BIT])
      else $error("service line differs from request bit");
   AST_ERRQ_SET: assert property (errq_not_empty_i [*3] |-> stb_o[STB_ERRQ_BIT])
      else $error("queue bit missing");
   AST_ERRQ_CLR: assert property (!errq_not_empty_i [*3] |-> !stb_o[STB_ERRQ_BIT])
      else $error("queue bit stuck");
   AST_CLS_FLUSH: assert property (cls_i |=> errq_clear_o)
      else $error("clear did not flush queue");
   AST_FLUSH_CAUSE: assert property (errq_clear_o |-> $past(cls_i) || $past(mode_change_i))
      else $error("flush without cause");
   AST_ESE_WRITE: assert property (ese_wr_i && !mode_change_i |=> ese_o == $past(ese_wdata_i))
      else $error("event enable not stored");
   AST_ESE_HOLD: assert property (!ese_wr_i && !mode_change_i |=> $stable(ese_o))
      else $error("event enable changed alone");
   AST_SRE_WRITE: assert property (sre_wr_i && !mode_change_i |=> sre_o == $past(sre_wdata_i))
      else $error("service enable not stored");
   AST_MODE_DEFAULT: assert property (s_clean_mode |=> ese_o == ESE_RST && sre_o == SRE_RST)
      else $error("masks not back to defaults");
   AST_POLL_CLEARS: assert property (s_poll |-> s_rqs_gone)
      else $error("poll left request bit set");
   AST_RQS_CAUSE: assert property ($rose(stb_o[STB_RQS_BIT]) |-> |($past(stb_o) & $past(sre_o, 2) & 8'hBF))
      else $error("request without enabled summary");
endmodule
bind status_reporting_hierarchy status_checker i_status_checker (.clk_sys_i, .rst_b_i,
   .errq_not_empty_i, .mode_change_i, .cls_i, .ese_wr_i, .ese_wdata_i, .sre_wr_i,
   .sre_wdata_i, .spoll_i, .ese_o, .sre_o, .stb_o, .errq_clear_o, .srq_o);

// ===== sim/controller_model.sv
// ==========================================================
// Remote controller: periodic queries and serial polls
module controller_model (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic srq_i,             // Service request line
   input wire logic auto_poll_i,       // Answer requests at all
   input wire logic [3:0] poll_dly_i,  // Reaction delay, prompt or slow
   output logic spoll_o,               // Serial poll pulse
   output logic query_o                // Status byte query pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_reg;  // Cycles since request seen
   logic [2:0] tick_reg;  // Query spacing
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_reg <= 3'h0;
      end else begin
         tick_reg <= tick_reg + 3'h1;
      end
   end
   assign query_o = (tick_reg == 3'h7);
   // Poll once per request; the drop takes two edges, so a delay of three avoids a repeat
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_reg <= 4'h0;
         spoll_o <= 1'b0;
      end else begin
         spoll_o <= 1'b0;
         if (!auto_poll_i || !srq_i || spoll_o) begin
            wait_reg <= 4'h0;
         end else if (wait_reg == poll_dly_i) begin
            spoll_o <= 1'b1;
            wait_reg <= 4'h0;
         end else begin
            wait_reg <= wait_reg + 4'h1;
         end
      end
   end
endmodule

// ===== sim/test_status_reporting_hierarchy.sv
module test_status_reporting_hierarchy;
   timeunit 1ns;
   timeprecision 1ps;
   import status_pkg::*;
   // ==========================================================
   // Signals
   logic clk_sys_i, rst_b_i, errq_not_empty_i, ops_idle_i, mode_change_i, grp_wr_i, grp_rd_i;
   logic [GRP_W-1:0] ques_cond_i, oper_cond_i, sub_cond_i, grp_wdata_i, grp_rdata_o;
   logic [ESR_W-1:0] esr_set_i, ese_wdata_i, ese_o, esr_rdata_o;
   logic [STB_W-1:0] sre_wdata_i, sre_o, stb_o;
   logic cls_i, ese_wr_i, esr_rd_i, opc_i, sre_wr_i, stb_rd_i, spoll_i, errq_clear_o, srq_o;
   grp_sel_t grp_sel_i;
   grp_fld_t grp_fld_i;
   logic auto_poll;        // Controller answers requests
   logic [3:0] poll_dly;   // Controller reaction time
   int bad_count = 0, num_checks = 0;
   status_reporting_hierarchy i_status_reporting_hierarchy (.clk_sys_i, .rst_b_i,
      .ques_cond_i, .oper_cond_i, .sub_cond_i, .errq_not_empty_i, .esr_set_i, .ops_idle_i,
      .mode_change_i, .grp_sel_i, .grp_fld_i, .grp_wr_i, .grp_rd_i, .grp_wdata_i,
      .grp_rdata_o, .cls_i, .ese_wr_i, .ese_wdata_i, .ese_o, .esr_rd_i, .esr_rdata_o, .opc_i,
      .sre_wr_i, .sre_wdata_i, .sre_o, .stb_rd_i, .spoll_i, .stb_o, .errq_clear_o, .srq_o);
   controller_model i_controller_model (.clk_sys_i, .rst_b_i, .srq_i(srq_o),
      .auto_poll_i(auto_poll), .poll_dly_i(poll_dly), .spoll_o(spoll_i), .query_o(stb_rd_i));
   // ==========================================================
   // Helpers
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task close_out;
      if (bad_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("Error %0t: %s", $time, msg);
      end
   endtask
   // Scenario inputs change 2 ns after the edge; the controller model drives its pulses at the edge
   task tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #2;
   endtask
   // Bounded wait on the request line
   task wait_srq(input logic lvl);
      for (int i = 0; i < 24 && srq_o !== lvl; i++) tick(1);
      if (srq_o !== lvl) begin
         bad_count++;
         $display("Error %0t: request line stuck", $time);
         close_out();
      end
   endtask
   task grp_wr(input grp_sel_t s, input grp_fld_t f, input logic [GRP_W-1:0] v);
      grp_sel_i = s;
      grp_fld_i = f;
      grp_wdata_i = v;
      grp_wr_i = 1'b1;
      tick(1);
      grp_wr_i = 1'b0;
      tick(1);
   endtask
   task grp_rd(input grp_sel_t s, input grp_fld_t f, output logic [GRP_W-1:0] v);
      grp_sel_i = s;
      grp_fld_i = f;
      grp_rd_i = 1'b1;
      tick(1);
      grp_rd_i = 1'b0;
      v = grp_rdata_o;
      tick(1);
   endtask
   task esr_read(output logic [ESR_W-1:0] v);
      esr_rd_i = 1'b1;
      tick(1);
      esr_rd_i = 1'b0;
      v = esr_rdata_o;
      tick(1);
   endtask
   task mask_wr(input logic [ESR_W-1:0] ese, input logic [STB_W-1:0] sre);
      ese_wdata_i = ese;
      sre_wdata_i = sre;
      ese_wr_i = 1'b1;
      sre_wr_i = 1'b1;
      tick(1);
      ese_wr_i = 1'b0;
      sre_wr_i = 1'b0;
      tick(1);
   endtask
   // ==========================================================
   // Scenarios
   task t_reset;
      logic [GRP_W-1:0] v;
      chk(ese_o === ESE_RST && sre_o === SRE_RST, "mask reset");
      grp_rd(GRP_OPER, FLD_PTR, v);
      chk(v === PTR_RST, "rising filter reset");
      grp_rd(GRP_QUES, FLD_NTR, v);
      chk(v === NTR_RST, "falling filter reset");
   endtask
   // Rising edge, sticky event, request, slow serial poll
   task t_rise;
      logic [GRP_W-1:0] v;
      grp_wr(GRP_OPER, FLD_ENA, 16'h0001);
      mask_wr(8'h00, 8'h80);
      chk(sre_o === 8'h80, "service enable readback");
      oper_cond_i = 16'h0001;
      wait_srq(1'b1);
      chk(stb_o === 8'hC0, "byte with request");
      oper_cond_i = 16'h0000;
      tick(4);
      chk(stb_o[7] === 1'b1, "event not sticky");
      poll_dly = 4'hC;
      auto_poll = 1'b1;
      wait_srq(1'b0);
      chk(stb_o === 8'h80, "poll touched other bits");
      auto_poll = 1'b0;
      grp_rd(GRP_OPER, FLD_EVT, v);
      chk(v === 16'h0001, "event contents");
      tick(3);
      chk(stb_o === 8'h00, "summary after event read");
   endtask
   // Falling filter, sub group path, clear status
   task t_fall;
      grp_wr(GRP_QUES, FLD_PTR, 16'h8000);
      grp_wr(GRP_QUES, FLD_NTR, 16'h0001);
      grp_wr(GRP_QUES, FLD_ENA, 16'h8001);
      ques_cond_i = 16'h0001;
      tick(5);
      chk(stb_o[3] === 1'b0, "rise caught without filter");
      ques_cond_i = 16'h0000;
      tick(5);
      chk(stb_o[3] === 1'b1, "fall missed");
      cls_i = 1'b1;
      tick(1);
      cls_i = 1'b0;
      chk(errq_clear_o === 1'b1, "no queue flush");
      tick(4);
      chk(stb_o[3] === 1'b0, "clear left summary");
      grp_wr(GRP_SUB, FLD_ENA, 16'h0001);
      sub_cond_i = 16'h0001;
      tick(8);
      chk(stb_o[3] === 1'b1, "sub summary lost");
   endtask
   // Event status enable, operation complete, read-clear, prompt poll
   task t_esr;
      logic [ESR_W-1:0] v;
      mask_wr(8'h41, 8'h20);
      chk(ese_o === 8'h41, "event enable readback");
      ops_idle_i = 1'b0;
      opc_i = 1'b1;
      tick(1);
      opc_i = 1'b0;
      tick(3);
      chk(stb_o[5] === 1'b0, "complete while busy");
      poll_dly = 4'h3;
      auto_poll = 1'b1;
      ops_idle_i = 1'b1;
      esr_set_i = 8'h20;
      tick(1);
      esr_set_i = 8'h00;
      wait_srq(1'b1);
      wait_srq(1'b0);
      chk(stb_o[6] === 1'b0 && stb_o[5] === 1'b1, "poll result");
      auto_poll = 1'b0;
      esr_read(v);
      chk(v === 8'h21, "event status contents");
      esr_read(v);
      chk(v === 8'h00, "read did not clear");
   endtask
   // Mode change restores defaults and flags power-up
   task t_mode;
      logic [GRP_W-1:0] v;
      logic [ESR_W-1:0] e;
      mask_wr(8'hFF, 8'h28);
      mode_change_i = 1'b1;
      tick(1);
      mode_change_i = 1'b0;
      chk(errq_clear_o === 1'b1, "mode change flush");
      chk(ese_o === ESE_RST && sre_o === SRE_RST, "masks kept");
      grp_rd(GRP_QUES, FLD_PTR, v);
      chk(v === PTR_RST, "filter kept");
      grp_rd(GRP_QUES, FLD_ENA, v);
      chk(v === ENA_RST, "enable kept");
      esr_read(e);
      chk(e === 8'h80, "power-up bit");
   endtask
   // Queue bit, and queries that must not disturb the byte
   task t_errq;
      sub_cond_i = 16'h0000;
      errq_not_empty_i = 1'b1;
      tick(4);
      chk(stb_o === 8'h04, "queue bit missing");
      tick(16);
      chk(stb_o === 8'h04, "query changed byte");
      errq_not_empty_i = 1'b0;
      tick(4);
      chk(stb_o === 8'h00, "queue bit stuck");
   endtask
   initial begin
      {rst_b_i, errq_not_empty_i, mode_change_i, grp_wr_i, grp_rd_i, cls_i} = '0;
      {ese_wr_i, esr_rd_i, opc_i, sre_wr_i, auto_poll} = '0;
      {ques_cond_i, oper_cond_i, sub_cond_i, grp_wdata_i} = '0;
      {esr_set_i, ese_wdata_i, sre_wdata_i} = '0;
      ops_idle_i = 1'b1;
      poll_dly = 4'h3;
      grp_sel_i = GRP_NONE;
      grp_fld_i = FLD_PTR;
      repeat (16) @(posedge clk_sys_i);
      #2;
      rst_b_i = 1'b1;
      tick(1);
      t_reset();
      t_rise();
      t_fall();
      t_esr();
      t_mode();
      t_errq();
      close_out();
   end
endmodule
